/* File: logic/mmcr_regs.sv */
// Index/data configuration register bank of the memory map controller.
`timescale 1ns/1ps
// Overview of operation
// - Index port selects register, data port accesses it.
// - Bits enable shadow RAM, A0000H to BFFFFH.
// - Bits enable shadow RAM, C0000H to DFFFFH.
// - Bits enable shadow RAM, E0000H to FFFFFH.
// - Primary bank bit 5 picks one/two banks.
// - Primary bank bits 7:6 give DRAM type.
// - ROM wait states equal field, default three.
// - Expanded wait states zero to two, default two.
// - Bit 4 enables expanded memory mapping.
// - Bit 5 selects RAM zero/one wait.
// - Relocation moves 512K-640K above 1M, only with 1M RAM.
// - Bit 7 selects page/interleaved DRAM mode.
// - Secondary bank bit 5 picks one/two banks.
// - Secondary bank bits 7:6 give local type.
// - Low nibble selects expanded page I/O pair.
// - High nibble selects four-page frame base.
// - Each page has a 2-bit block select.
// - Block select maps page into 2M region.
// - Boot firmware sets DRAM type from CMOS.
module mmcr_regs (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        io_wr,
  input  wire logic        io_rd,
  input  wire logic [7:0]  io_addr,
  input  wire logic [7:0]  io_wdata,
  input  wire logic        ram_is_1m,
  output logic [7:0]       io_rdata,
  output logic             io_rdata_en,
  output logic [23:0]      shadow_en,
  output logic             prim_two_banks,
  output logic [1:0]       prim_dram_type,
  output logic             sec_two_banks,
  output logic [1:0]       sec_dram_type,
  output logic [1:0]       rom_wait,
  output logic [1:0]       exp_wait,
  output logic             exp_enable,
  output logic             ram_wait,
  output logic             reloc_active,
  output logic             page_il_mode,
  output logic [9:0]       exp_io_base,
  output logic             exp_io_valid,
  output logic [19:0]      exp_frame_base,
  output logic             exp_frame_valid,
  output logic [7:0]       exp_page_block,
  output logic [7:0]       misc_q_out
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [1:0] wr_s1_q;
  logic [1:0] wr_s2_q;
  logic [7:0] addr_s1_q;
  logic [7:0] addr_s2_q;
  logic [7:0] wdata_s1_q;
  logic [7:0] wdata_s2_q;
  logic [1:0] ram1m_sq;
  logic       wr_prev_q;
  logic       rd_prev_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_s1_q    <= 2'h0;
      wr_s2_q    <= 2'h0;
      addr_s1_q  <= 8'h00;
      addr_s2_q  <= 8'h00;
      wdata_s1_q <= 8'h00;
      wdata_s2_q <= 8'h00;
      ram1m_sq   <= 2'h0;
    end else begin
      wr_s1_q    <= {io_rd, io_wr};
      wr_s2_q    <= wr_s1_q;
      addr_s1_q  <= io_addr;
      addr_s2_q  <= addr_s1_q;
      wdata_s1_q <= io_wdata;
      wdata_s2_q <= wdata_s1_q;
      ram1m_sq   <= {ram1m_sq[0], ram_is_1m};
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_prev_q <= 1'b0;
      rd_prev_q <= 1'b0;
    end else begin
      wr_prev_q <= wr_s2_q[0];
      rd_prev_q <= wr_s2_q[1];
    end
  end

  // Strobes fire once on the rising edge of each synchronised command.
  logic wr_stb;
  logic rd_stb;
  assign wr_stb = wr_s2_q[0] && !wr_prev_q;
  assign rd_stb = wr_s2_q[1] && !rd_prev_q;

  // ****************************************
  // Index latch and access arming
  // ****************************************
  mmcr_pkg::mmcr_state_e state_q;
  logic [7:0]            index_q;
  logic                  idx_wr;
  logic                  data_acc;
  assign idx_wr   = wr_stb && (addr_s2_q == mmcr_pkg::IO_INDEX_PORT);
  assign data_acc = (wr_stb || rd_stb) && (addr_s2_q == mmcr_pkg::IO_DATA_PORT);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= mmcr_pkg::MMCR_IDLE;
    end else begin
      case (state_q)
        mmcr_pkg::MMCR_IDLE:  if (idx_wr) state_q <= mmcr_pkg::MMCR_ARMED;
        mmcr_pkg::MMCR_ARMED: if (data_acc) state_q <= mmcr_pkg::MMCR_IDLE;
        default:              state_q <= mmcr_pkg::MMCR_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      index_q <= 8'h00;
    end else if (idx_wr) begin
      index_q <= wdata_s2_q;
    end
  end

  logic data_wr;
  logic data_rd;
  assign data_wr = data_acc && wr_stb && (state_q == mmcr_pkg::MMCR_ARMED);
  assign data_rd = data_acc && rd_stb && (state_q == mmcr_pkg::MMCR_ARMED);

  // ****************************************
  // Configuration registers
  // ****************************************
  logic [7:0] shadow_ab_q;
  logic [7:0] shadow_cd_q;
  logic [7:0] shadow_ef_q;
  logic [7:0] prim_bank_q;
  logic [7:0] dram_wait_q;
  logic [7:0] sec_bank_q;
  logic [7:0] exp_base_q;
  logic [7:0] exp_blocks_q;
  logic [7:0] misc_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      shadow_ab_q  <= mmcr_pkg::RST_SHADOW;
      shadow_cd_q  <= mmcr_pkg::RST_SHADOW;
      shadow_ef_q  <= mmcr_pkg::RST_SHADOW;
      prim_bank_q  <= mmcr_pkg::RST_PRIM_BANK;
      dram_wait_q  <= mmcr_pkg::RST_DRAM_WAIT;
      sec_bank_q   <= mmcr_pkg::RST_SEC_BANK;
      exp_base_q   <= mmcr_pkg::RST_EXP_BASE;
      exp_blocks_q <= mmcr_pkg::RST_EXP_BLOCKS;
      misc_q       <= mmcr_pkg::RST_MISC;
    end else if (data_wr) begin
      if (index_q == mmcr_pkg::IDX_SHADOW_AB) begin
        shadow_ab_q <= wdata_s2_q;
      end else if (index_q == mmcr_pkg::IDX_SHADOW_CD) begin
        shadow_cd_q <= wdata_s2_q;
      end else if (index_q == mmcr_pkg::IDX_SHADOW_EF) begin
        shadow_ef_q <= wdata_s2_q;
      end else if (index_q == mmcr_pkg::IDX_PRIM_BANK) begin
        prim_bank_q <= wdata_s2_q & mmcr_pkg::BANK_WMASK;
      end else if (index_q == mmcr_pkg::IDX_DRAM_WAIT) begin
        dram_wait_q <= wdata_s2_q;
      end else if (index_q == mmcr_pkg::IDX_SEC_BANK) begin
        sec_bank_q <= wdata_s2_q & mmcr_pkg::BANK_WMASK;
      end else if (index_q == mmcr_pkg::IDX_EXP_BASE) begin
        exp_base_q <= wdata_s2_q;
      end else if (index_q == mmcr_pkg::IDX_EXP_BLOCKS) begin
        exp_blocks_q <= wdata_s2_q;
      end else if (index_q == mmcr_pkg::IDX_MISC) begin
        misc_q <= wdata_s2_q & mmcr_pkg::MISC_WMASK;
      end
    end
  end

  // ****************************************
  // Read multiplexer
  // ****************************************
  logic [7:0] rd_mux;
  logic       rd_hit;
  always_comb begin
    rd_hit = 1'b1;
    if (index_q == mmcr_pkg::IDX_SHADOW_AB) begin
      rd_mux = shadow_ab_q;
    end else if (index_q == mmcr_pkg::IDX_SHADOW_CD) begin
      rd_mux = shadow_cd_q;
    end else if (index_q == mmcr_pkg::IDX_SHADOW_EF) begin
      rd_mux = shadow_ef_q;
    end else if (index_q == mmcr_pkg::IDX_PRIM_BANK) begin
      rd_mux = prim_bank_q;
    end else if (index_q == mmcr_pkg::IDX_DRAM_WAIT) begin
      rd_mux = dram_wait_q;
    end else if (index_q == mmcr_pkg::IDX_SEC_BANK) begin
      rd_mux = sec_bank_q;
    end else if (index_q == mmcr_pkg::IDX_EXP_BASE) begin
      rd_mux = exp_base_q;
    end else if (index_q == mmcr_pkg::IDX_EXP_BLOCKS) begin
      rd_mux = exp_blocks_q;
    end else if (index_q == mmcr_pkg::IDX_MISC) begin
      rd_mux = misc_q;
    end else begin
      rd_mux = 8'h00;
      rd_hit = 1'b0;
    end
  end

  // Read data is captured on an armed data-port read and held until the next such read; any write strobe clears io_rdata_en.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      io_rdata    <= 8'h00;
      io_rdata_en <= 1'b0;
    end else if (data_rd) begin
      io_rdata    <= rd_mux;
      io_rdata_en <= rd_hit;
    end else if (wr_stb) begin
      io_rdata_en <= 1'b0;
    end
  end

  // ****************************************
  // Expanded memory decode
  // ****************************************
  mmcr_cfg_if cfg ();
  assign cfg.ems_io_sel = exp_base_q;
  assign cfg.frame_sel  = exp_base_q[mmcr_pkg::FRAME_SEL_LSB +: 4];
  assign cfg.ems_on     = dram_wait_q[mmcr_pkg::EXP_EN_BIT];

  mmcr_ems_decode u_dec (
    .cfg (cfg.dec)
  );

  // ****************************************
  // Registered field outputs
  // ****************************************
  logic [1:0] exp_ws_field;
  assign exp_ws_field = dram_wait_q[mmcr_pkg::EXP_WS_LSB +: 2];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      shadow_en       <= 24'h000000;
      prim_two_banks  <= 1'b0;
      prim_dram_type  <= 2'h0;
      sec_two_banks   <= 1'b0;
      sec_dram_type   <= 2'h0;
      rom_wait        <= 2'h0;
      exp_wait        <= 2'h0;
      exp_enable      <= 1'b0;
      ram_wait        <= 1'b0;
      reloc_active    <= 1'b0;
      page_il_mode    <= 1'b0;
      exp_io_base     <= 10'h000;
      exp_io_valid    <= 1'b0;
      exp_frame_base  <= 20'h00000;
      exp_frame_valid <= 1'b0;
      exp_page_block  <= 8'h00;
      misc_q_out      <= 8'h00;
    end else begin
      shadow_en      <= {shadow_ef_q, shadow_cd_q, shadow_ab_q};
      prim_two_banks <= prim_bank_q[mmcr_pkg::BANK_TWO_BIT];
      prim_dram_type <= prim_bank_q[mmcr_pkg::BANK_TYPE_LSB +: 2];
      sec_two_banks  <= sec_bank_q[mmcr_pkg::BANK_TWO_BIT];
      sec_dram_type  <= sec_bank_q[mmcr_pkg::BANK_TYPE_LSB +: 2];
      rom_wait       <= dram_wait_q[mmcr_pkg::ROM_WS_LSB +: 2];
      exp_wait       <= (exp_ws_field == mmcr_pkg::EXP_WS_RSVD) ? 2'h2 : exp_ws_field;
      exp_enable     <= dram_wait_q[mmcr_pkg::EXP_EN_BIT];
      ram_wait       <= dram_wait_q[mmcr_pkg::RAM_WS_BIT];
      reloc_active   <= dram_wait_q[mmcr_pkg::RELOC_BIT] && ram1m_sq[1];
      page_il_mode   <= dram_wait_q[mmcr_pkg::PAGE_IL_BIT];
      exp_io_base    <= cfg.io_base;
      exp_io_valid   <= cfg.io_valid;
      exp_frame_base <= cfg.frame_base;
      exp_frame_valid <= cfg.frame_valid;
      exp_page_block <= exp_blocks_q;
      misc_q_out     <= misc_q;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  property p_data_needs_index;
    @(posedge clk) disable iff (!arst_n)
      (data_acc && state_q == mmcr_pkg::MMCR_ARMED) |=> (state_q == mmcr_pkg::MMCR_IDLE);
  endproperty
  a_data_needs_index: assert property (p_data_needs_index) else $error("Arming not consumed.");

  property p_index_latch;
    @(posedge clk) disable iff (!arst_n)
      idx_wr |=> (index_q == $past(wdata_s2_q) && state_q == mmcr_pkg::MMCR_ARMED);
  endproperty
  a_index_latch: assert property (p_index_latch) else $error("Index not latched.");

  property p_reserved_zero;
    @(posedge clk) disable iff (!arst_n)
      (prim_bank_q[4:0] == 5'h00) && (sec_bank_q[4:0] == 5'h00);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("Reserved bits set.");

  property p_shadow_write;
    @(posedge clk) disable iff (!arst_n)
      (data_wr && index_q == mmcr_pkg::IDX_SHADOW_CD) |=> ##1 (shadow_en[15:8] == $past(wdata_s2_q, 2));
  endproperty
  a_shadow_write: assert property (p_shadow_write) else $error("Shadow enable not updated.");

  property p_rom_wait;
    @(posedge clk) disable iff (!arst_n)
      (data_wr && index_q == mmcr_pkg::IDX_DRAM_WAIT) |=> ##1 (rom_wait == $past(wdata_s2_q[1:0], 2));
  endproperty
  a_rom_wait: assert property (p_rom_wait) else $error("Rom wait not updated.");

  property p_exp_wait_legal;
    @(posedge clk) disable iff (!arst_n) exp_wait != 2'h3;
  endproperty
  a_exp_wait_legal: assert property (p_exp_wait_legal) else $error("Expanded wait reserved.");

  property p_reloc;
    @(posedge clk) disable iff (!arst_n)
      reloc_active |-> $past(ram1m_sq[1]) && $past(dram_wait_q[mmcr_pkg::RELOC_BIT]);
  endproperty
  a_reloc: assert property (p_reloc) else $error("Relocation without 1M.");

  property p_frame_range;
    @(posedge clk) disable iff (!arst_n)
      exp_frame_valid |-> (exp_frame_base >= 20'hc0000 && exp_frame_base <= 20'he0000 && exp_enable);
  endproperty
  a_frame_range: assert property (p_frame_range) else $error("Frame base out of range.");

  property p_refused_write;
    @(posedge clk) disable iff (!arst_n)
      (data_acc && wr_stb && state_q == mmcr_pkg::MMCR_IDLE) |=>
        $stable({shadow_ab_q, shadow_cd_q, shadow_ef_q, prim_bank_q, dram_wait_q, sec_bank_q, exp_base_q,
                 exp_blocks_q, misc_q});
  endproperty
  a_refused_write: assert property (p_refused_write) else $error("Data write taken without index.");

  property p_unmapped_read;
    @(posedge clk) disable iff (!arst_n)
      (data_rd && !rd_hit) |=> (io_rdata == 8'h00 && !io_rdata_en);
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("Unmapped index read not empty.");

endmodule : mmcr_regs

/* File: shared/mmcr_pkg.sv */
// Package with register indices, field positions and reset values of the memory map configuration bank.
package mmcr_pkg;

  // ****************************************
  // I/O ports and register indices
  // ****************************************
  localparam logic [7:0] IO_INDEX_PORT   = 8'h22;
  localparam logic [7:0] IO_DATA_PORT    = 8'h23;
  localparam logic [7:0] IDX_SHADOW_AB   = 8'h67;
  localparam logic [7:0] IDX_SHADOW_CD   = 8'h68;
  localparam logic [7:0] IDX_SHADOW_EF   = 8'h69;
  localparam logic [7:0] IDX_PRIM_BANK   = 8'h6a;
  localparam logic [7:0] IDX_DRAM_WAIT   = 8'h6b;
  localparam logic [7:0] IDX_SEC_BANK    = 8'h6c;
  localparam logic [7:0] IDX_EXP_BASE    = 8'h6d;
  localparam logic [7:0] IDX_EXP_BLOCKS  = 8'h6e;
  localparam logic [7:0] IDX_MISC        = 8'h6f;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] RST_SHADOW      = 8'h00;
  localparam logic [7:0] RST_PRIM_BANK   = 8'h80;
  localparam logic [7:0] RST_DRAM_WAIT   = 8'h6b;
  localparam logic [7:0] RST_SEC_BANK    = 8'h00;
  localparam logic [7:0] RST_EXP_BASE    = 8'h00;
  localparam logic [7:0] RST_EXP_BLOCKS  = 8'h00;
  localparam logic [7:0] RST_MISC        = 8'h00;

  // ****************************************
  // Field positions and writable masks
  // ****************************************
  localparam int BANK_TWO_BIT    = 5;
  localparam int BANK_TYPE_LSB   = 6;
  localparam int ROM_WS_LSB      = 0;
  localparam int EXP_WS_LSB      = 2;
  localparam int EXP_EN_BIT      = 4;
  localparam int RAM_WS_BIT      = 5;
  localparam int RELOC_BIT       = 6;
  localparam int PAGE_IL_BIT     = 7;
  localparam int IO_SEL_LSB      = 0;
  localparam int FRAME_SEL_LSB   = 4;
  localparam logic [7:0] BANK_WMASK = 8'he0;
  localparam logic [7:0] MISC_WMASK = 8'he6;

  // ****************************************
  // Encodings
  // ****************************************
  localparam logic [3:0] FRAME_SEL_MAX   = 4'h8;
  localparam logic [19:0] FRAME_BASE     = 20'hc0000;
  localparam logic [19:0] PAGE_SIZE      = 20'h04000;
  localparam logic [1:0] EXP_WS_RSVD     = 2'h3;

  typedef enum logic [1:0] {
    MMCR_IDLE  = 2'b00,
    MMCR_ARMED = 2'b01
  } mmcr_state_e;

endpackage : mmcr_pkg

/* File: shared/mmcr_cfg_if.sv */
// Interface carrying configuration fields from the register bank to the decoder and the decoded bases and valid flags back.
`timescale 1ns/1ps
interface mmcr_cfg_if;
  logic [7:0] ems_io_sel;
  logic [3:0] frame_sel;
  logic       ems_on;
  logic [9:0] io_base;
  logic       io_valid;
  logic [19:0] frame_base;
  logic       frame_valid;
  modport bank (output ems_io_sel, output frame_sel, output ems_on, input io_base, input io_valid,
                input frame_base, input frame_valid);
  modport dec  (input ems_io_sel, input frame_sel, input ems_on, output io_base, output io_valid,
                output frame_base, output frame_valid);
endinterface : mmcr_cfg_if

/* File: logic/mmcr_ems_decode.sv */
// Decoder of the expanded-memory I/O pair and page-frame base.
`timescale 1ns/1ps
module mmcr_ems_decode (
  mmcr_cfg_if.dec cfg
);

  // ****************************************
  // Page register I/O base
  // ****************************************
  always_comb begin
    cfg.io_valid = cfg.ems_on;
    case (cfg.ems_io_sel[3:0])
      4'h0: cfg.io_base = 10'h208;
      4'h1: cfg.io_base = 10'h218;
      4'h5: cfg.io_base = 10'h258;
      4'h6: cfg.io_base = 10'h268;
      4'ha: cfg.io_base = 10'h2a8;
      4'hb: cfg.io_base = 10'h2b8;
      4'he: cfg.io_base = 10'h2e8;
      default: begin
        cfg.io_base  = 10'h000;
        cfg.io_valid = 1'b0;
      end
    endcase
  end

  // ****************************************
  // Page frame base
  // ****************************************
  always_comb begin
    cfg.frame_valid = cfg.ems_on && (cfg.frame_sel <= mmcr_pkg::FRAME_SEL_MAX);
    cfg.frame_base  = cfg.frame_valid
                      ? 20'(mmcr_pkg::FRAME_BASE + mmcr_pkg::PAGE_SIZE * 20'(cfg.frame_sel)) : 20'h00000;
  end

endmodule : mmcr_ems_decode

/* File: sim/memory_map_config_regs_tb.sv */
// Self-checking testbench of the memory map configuration register bank.
`timescale 1ns/1ps
module memory_map_config_regs_tb;
  typedef struct {int sel; logic [31:0] exp;} mmcr_note_s;
  localparam logic [7:0] DFLT [0:8] = '{8'h00, 8'h00, 8'h00, 8'h80, 8'h6b, 8'h00, 8'h00, 8'h00, 8'h00};
  logic        clk;
  logic        arst_n;
  logic        io_wr;
  logic        io_rd;
  logic [7:0]  io_addr;
  logic [7:0]  io_wdata;
  logic        ram_is_1m;
  logic [7:0]  io_rdata;
  logic        io_rdata_en;
  logic [23:0] shadow_en;
  logic        prim_two_banks;
  logic [1:0]  prim_dram_type;
  logic        sec_two_banks;
  logic [1:0]  sec_dram_type;
  logic [1:0]  rom_wait;
  logic [1:0]  exp_wait;
  logic        exp_enable;
  logic        ram_wait;
  logic        reloc_active;
  logic        page_il_mode;
  logic [9:0]  exp_io_base;
  logic        exp_io_valid;
  logic [19:0] exp_frame_base;
  logic        exp_frame_valid;
  logic [7:0]  exp_page_block;
  logic [7:0]  misc_q_out;
  mmcr_note_s  notes [$];
  event        look;
  int          errors;
  int          checks;
  logic [31:0] seed;

  mmcr_regs mmcr_regs_inst (
    .clk(clk), .arst_n(arst_n), .io_wr(io_wr), .io_rd(io_rd), .io_addr(io_addr), .io_wdata(io_wdata),
    .ram_is_1m(ram_is_1m), .io_rdata(io_rdata), .io_rdata_en(io_rdata_en), .shadow_en(shadow_en),
    .prim_two_banks(prim_two_banks), .prim_dram_type(prim_dram_type), .sec_two_banks(sec_two_banks),
    .sec_dram_type(sec_dram_type), .rom_wait(rom_wait), .exp_wait(exp_wait), .exp_enable(exp_enable),
    .ram_wait(ram_wait), .reloc_active(reloc_active), .page_il_mode(page_il_mode),
    .exp_io_base(exp_io_base), .exp_io_valid(exp_io_valid), .exp_frame_base(exp_frame_base),
    .exp_frame_valid(exp_frame_valid), .exp_page_block(exp_page_block), .misc_q_out(misc_q_out)
  );

  // ****************************************
  // Clock, stimulus helpers and expectations
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction : xs

  task automatic rnd(output logic [7:0] v);
    seed = xs(seed);
    v = seed[7:0];
  endtask : rnd

  // Expected page-register pair base with its valid flag in the top bit.
  function automatic logic [10:0] io_exp(input logic [3:0] c);
    case (c)
      4'h0: return {1'b1, 10'h208};
      4'h1: return {1'b1, 10'h218};
      4'h5: return {1'b1, 10'h258};
      4'h6: return {1'b1, 10'h268};
      4'ha: return {1'b1, 10'h2a8};
      4'hb: return {1'b1, 10'h2b8};
      4'he: return {1'b1, 10'h2e8};
      default: return 11'h000;
    endcase
  endfunction : io_exp

  // Bases are masked while invalid, since their value there is unspecified.
  function automatic logic [31:0] field(input int sel);
    case (sel)
      1: return {8'h00, shadow_en};
      2: return {24'h0, rom_wait, exp_wait, exp_enable, ram_wait, reloc_active, page_il_mode};
      3: return {26'h0, prim_dram_type, prim_two_banks, sec_dram_type, sec_two_banks};
      4: return {exp_io_valid, exp_io_valid ? exp_io_base : 10'h000, exp_frame_valid,
                 exp_frame_valid ? exp_frame_base : 20'h00000};
      5: return {24'h0, exp_page_block};
      default: return {24'h0, misc_q_out};
    endcase
  endfunction : field

  // Strobes are held four cycles and kept low four cycles, as the synchroniser needs.
  task automatic io(input logic wr, input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk);
    io_addr  <= addr;
    io_wdata <= data;
    repeat (3) @(posedge clk);
    io_wr <= wr;
    io_rd <= !wr;
    repeat (4) @(posedge clk);
    io_wr <= 1'b0;
    io_rd <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : io

  task automatic note(input int sel, input logic [31:0] exp);
    mmcr_note_s n;
    n.sel = sel;
    n.exp = exp;
    notes.push_back(n);
    #1;
    ->look;
  endtask : note

  task automatic wreg(input logic [7:0] idx, input logic [7:0] v);
    io(1'b1, mmcr_pkg::IO_INDEX_PORT, idx);
    io(1'b1, mmcr_pkg::IO_DATA_PORT, v);
  endtask : wreg

  task automatic rreg(input logic [7:0] idx, input logic [7:0] v, input logic en);
    io(1'b1, mmcr_pkg::IO_INDEX_PORT, idx);
    io(1'b0, mmcr_pkg::IO_DATA_PORT, 8'h00);
    note(0, {23'h0, en, v});
  endtask : rreg

  task automatic do_reset();
    @(posedge clk);
    arst_n    <= 1'b0;
    ram_is_1m <= 1'b1;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
  endtask : do_reset

  task automatic check_defaults();
    for (int i = 0; i < 9; i++) begin
      rreg(mmcr_pkg::IDX_SHADOW_AB + 8'(i), DFLT[i], 1'b1);
    end
    note(1, 32'h0);
    note(2, {24'h0, 8'b11_10_0_1_1_0});
    note(3, {26'h0, 6'b10_0_00_0});
    note(4, 32'h0);
    note(5, 32'h0);
    note(6, 32'h0);
  endtask : check_defaults

  // ****************************************
  // Result checking and verdict
  // ****************************************
  task automatic cmp_read(input logic [8:0] exp);
    checks++;
    if ({io_rdata_en, io_rdata} !== exp) begin
      errors++;
      $display("CHECK FAILED read port expected %h seen %h", exp, {io_rdata_en, io_rdata});
    end
  endtask : cmp_read

  task automatic cmp_field(input int sel, input logic [31:0] exp);
    checks++;
    if (field(sel) !== exp) begin
      errors++;
      $display("CHECK FAILED field group %0d expected %h seen %h", sel, exp, field(sel));
    end
  endtask : cmp_field

  task automatic give_verdict();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict

  initial begin
    mmcr_note_s n;
    forever begin
      @(look);
      if (notes.size() == 0) begin
        errors++;
        $display("CHECK FAILED note queue expected entry seen empty");
      end else begin
        n = notes.pop_front();
        if (n.sel == 0) begin
          cmp_read(n.exp[8:0]);
        end else begin
          cmp_field(n.sel, n.exp);
        end
      end
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    $display("CHECK FAILED run length expected finish seen timeout");
    give_verdict();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [7:0]  a;
    logic [7:0]  b;
    logic [7:0]  c;
    logic [7:0]  v;
    logic [7:0]  w;
    logic [19:0] fr;
    arst_n    = 1'b0;
    io_wr     = 1'b0;
    io_rd     = 1'b0;
    io_addr   = 8'h00;
    io_wdata  = 8'h00;
    ram_is_1m = 1'b1;
    errors    = 0;
    checks    = 0;
    seed      = 32'hb69f7d11;
    do_reset();
    check_defaults();
    rnd(a);
    rnd(b);
    rnd(c);
    wreg(mmcr_pkg::IDX_SHADOW_AB, a);
    wreg(mmcr_pkg::IDX_SHADOW_CD, b);
    wreg(mmcr_pkg::IDX_SHADOW_EF, c);
    note(1, {8'h00, c, b, a});
    rreg(mmcr_pkg::IDX_SHADOW_EF, c, 1'b1);
    wreg(mmcr_pkg::IDX_SHADOW_CD, 8'h5a);
    io(1'b1, mmcr_pkg::IO_DATA_PORT, 8'ha5);
    rreg(mmcr_pkg::IDX_SHADOW_CD, 8'h5a, 1'b1);
    wreg(8'h70, 8'hff);
    note(1, {8'h00, c, 8'h5a, a});
    rreg(8'h70, 8'h00, 1'b0);
    for (int i = 0; i < 16; i++) begin
      rnd(a);
      v = {a[7:4], 4'(i)};
      @(posedge clk);
      ram_is_1m <= a[0];
      wreg(mmcr_pkg::IDX_DRAM_WAIT, v);
      note(2, {24'h0, v[1:0], (v[3:2] == 2'b11) ? 2'b10 : v[3:2], v[4], v[5], v[6] & a[0], v[7]});
      if (v[3:2] != 2'b11) begin
        rreg(mmcr_pkg::IDX_DRAM_WAIT, v, 1'b1);
      end
    end
    for (int i = 0; i < 8; i++) begin
      rnd(a);
      rnd(b);
      v = {i[2:1], a[0], 5'h00};
      w = {~i[2:1], b[0], 5'h00};
      wreg(mmcr_pkg::IDX_PRIM_BANK, v);
      wreg(mmcr_pkg::IDX_SEC_BANK, w);
      note(3, {26'h0, v[7:6], v[5], w[7:6], w[5]});
      rreg(mmcr_pkg::IDX_SEC_BANK, w & 8'he0, 1'b1);
    end
    wreg(mmcr_pkg::IDX_DRAM_WAIT, 8'h10);
    for (int i = 0; i < 16; i++) begin
      v = {4'(i), 4'(15 - i)};
      wreg(mmcr_pkg::IDX_EXP_BASE, v);
      fr = (i <= 8) ? 20'hc0000 + 20'(i * 16384) : 20'h00000;
      note(4, {io_exp(v[3:0]), i <= 8, fr});
      rreg(mmcr_pkg::IDX_EXP_BASE, v, 1'b1);
    end
    wreg(mmcr_pkg::IDX_DRAM_WAIT, 8'h00);
    note(4, 32'h0);
    wreg(mmcr_pkg::IDX_EXP_BLOCKS, 8'h1b);
    note(5, 32'h1b);
    wreg(mmcr_pkg::IDX_EXP_BLOCKS, 8'he4);
    note(5, 32'he4);
    rreg(mmcr_pkg::IDX_EXP_BLOCKS, 8'he4, 1'b1);
    wreg(mmcr_pkg::IDX_MISC, mmcr_pkg::MISC_WMASK);
    note(6, {24'h0, mmcr_pkg::MISC_WMASK});
    rreg(mmcr_pkg::IDX_MISC, mmcr_pkg::MISC_WMASK, 1'b1);
    do_reset();
    check_defaults();
    give_verdict();
  end
endmodule : memory_map_config_regs_tb
